//--- sprite_plane_surface_scaler_regs_bench.sv
// sprite_plane_surface_scaler_regs_bench: self-checking bench of the sprite register bank
`timescale 1ns/100ps
module sprite_plane_surface_scaler_regs_bench;
  logic        clk, rst, reg_wr, reg_rd, cs_flip;
  logic        vblank_start, pipe_disabled, sprite_disabled;
  logic        surface_tiled, rotate_180, src_key_en;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cs_flip_addr, linear_offset, surface_base;
  logic [31:0] pan_linear, gamma_word, got;
  logic [4:0]  down_ratio, gamma_idx;
  logic        reg_rvalid, pan_tiled, pan_corner_lr, scale_en, decimate, scale_ratio_ok, armed;
  logic [11:0] pan_x, pan_y, src_width;
  logic [7:0]  key_max_v, key_max_y, key_max_u;
  logic [1:0]  filter_sel, vphase;
  logic [10:0] src_height_m1;
  int          bad_count, n_tests, cycles;

  spsr_regs DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cs_flip(cs_flip), .cs_flip_addr(cs_flip_addr), .vblank_start(vblank_start),
    .pipe_disabled(pipe_disabled), .sprite_disabled(sprite_disabled),
    .surface_tiled(surface_tiled), .rotate_180(rotate_180), .src_key_en(src_key_en),
    .linear_offset(linear_offset), .down_ratio(down_ratio), .gamma_idx(gamma_idx),
    .surface_base(surface_base), .pan_tiled(pan_tiled), .pan_x(pan_x), .pan_y(pan_y),
    .pan_linear(pan_linear), .pan_corner_lr(pan_corner_lr), .key_max_v(key_max_v),
    .key_max_y(key_max_y), .key_max_u(key_max_u), .scale_en(scale_en),
    .filter_sel(filter_sel), .vphase(vphase), .src_width(src_width),
    .src_height_m1(src_height_m1), .decimate(decimate), .scale_ratio_ok(scale_ratio_ok),
    .armed(armed), .gamma_word(gamma_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // free-running 100 MHz display clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard; the whole sequence needs well under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare one value, four-state exact
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // one-cycle write strobe, dropped after the edge that takes it
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  // read strobe; data is taken the cycle after, when rvalid stands
  task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 reg_rd = 1'b1; reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(32'(reg_rvalid), 32'h0000_0001, "rvalid");
    chk(reg_rdata, e, "read data");
  endtask

  // one-cycle update point: {vblank, pipe off, sprite off}
  task automatic upd(input logic [2:0] sel);
    @(posedge clk);
    #1 {vblank_start, pipe_disabled, sprite_disabled} = sel;
    @(posedge clk);
    #1 {vblank_start, pipe_disabled, sprite_disabled} = 3'b000;
  endtask

  // expected gamma default: identity ramp points, then three top words
  function automatic logic [31:0] gexp(input int k);
    return (k < 16) ? spsr_pkg::GAMMA_STEP * 32'(k) : spsr_pkg::GAMMA_TOP_RST;
  endfunction

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; every input gets a value at time zero
  initial
  begin
    bad_count = 0; n_tests = 0; cycles = 0;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 20'h0_0000; reg_wdata = 32'h0000_0000;
    cs_flip = 1'b0; cs_flip_addr = 32'h0000_0000; vblank_start = 1'b0; pipe_disabled = 1'b0;
    sprite_disabled = 1'b0; surface_tiled = 1'b0; rotate_180 = 1'b0; src_key_en = 1'b0;
    linear_offset = 32'h0bad_cafe; down_ratio = 5'h00; gamma_idx = 5'h00;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    // reset contents
    rd_chk(spsr_pkg::OFS_SURF, 32'h0000_0000);
    rd_chk(spsr_pkg::OFS_KEYMAX, 32'h0000_0000);
    rd_chk(spsr_pkg::OFS_TILEOFF, 32'h0000_0000);
    rd_chk(spsr_pkg::OFS_LIVE, 32'h0000_0000);
    rd_chk(spsr_pkg::OFS_SCALE, 32'h0000_0000);
    for (int k = 0; k < 19; k++)
      rd_chk(spsr_pkg::OFS_GAMMA + 20'(4 * k), gexp(k));
    // scaler write alone must not go active at vblank without arming; no 64-bit format
    wr(spsr_pkg::OFS_SCALE, 32'hffff_ffff);
    rd_chk(spsr_pkg::OFS_SCALE, 32'hffff_07ff);
    upd(3'b100);
    chk(32'(scale_en), 32'h0000_0000, "scale unarmed");
    // surface write arms; sprite off loads armed scaler only; base field stays 4K aligned
    wr(spsr_pkg::OFS_SURF, 32'h1234_5678);
    rd_chk(spsr_pkg::OFS_SURF, 32'h1234_5000);
    chk(32'(armed), 32'h0000_0001, "armed set");
    rd_chk(spsr_pkg::OFS_LIVE, 32'h0000_0000);
    upd(3'b001);
    chk(32'(scale_en), 32'h0000_0001, "scale armed");
    chk(32'(armed), 32'h0000_0000, "armed clear");
    chk(surface_base, 32'h0000_0000, "surface on sprite off");
    chk(32'(filter_sel), 32'h0000_0003, "filter");
    chk(32'(src_width), 32'h0000_0800, "width max");
    chk(32'(src_height_m1), 32'h0000_07ff, "height");
    chk(32'(vphase), 32'(spsr_pkg::SPSR_PH_HALF), "phase half");
    upd(3'b100);
    chk(surface_base, 32'h1234_5000, "surface at vblank");
    rd_chk(spsr_pkg::OFS_LIVE, 32'h1234_5000);
    // field enable clear, smallest legal source size of 3x3
    wr(spsr_pkg::OFS_SCALE, 32'h8002_0002);
    wr(spsr_pkg::OFS_SURF, 32'h1234_5000);
    upd(3'b100);
    chk(32'(vphase), 32'(spsr_pkg::SPSR_PH_SCALE), "phase scale");
    chk(32'(src_width), 32'h0000_0003, "width min");
    // field enable set, offset clear, even width, loaded through pipe disable
    wr(spsr_pkg::OFS_SCALE, 32'h8803_0002);
    wr(spsr_pkg::OFS_SURF, 32'h1234_5000);
    upd(3'b010);
    chk(32'(vphase), 32'(spsr_pkg::SPSR_PH_ZERO), "phase zero");
    chk(32'(src_width), 32'h0000_0004, "width even");
    // ratio boundaries: upscale, unity, around 2:1 and 16:1
    for (int r = 0; r < 18; r++)
    begin
      @(posedge clk);
      #1 down_ratio = 5'(r);
      #1 chk(32'(decimate), 32'(r > 2), "decimate");
      chk(32'(scale_ratio_ok), 32'(r <= 16), "ratio ok");
    end
    // key upper bounds gated by source keying
    wr(spsr_pkg::OFS_KEYMAX, 32'hffab_cdef);
    rd_chk(spsr_pkg::OFS_KEYMAX, 32'h00ab_cdef);
    upd(3'b010);
    chk(32'(key_max_v), 32'h0000_0000, "key off");
    @(posedge clk);
    #1 src_key_en = 1'b1;
    #1 chk({8'h00, key_max_v, key_max_y, key_max_u}, 32'h00ab_cdef, "key on");
    // tiled pan offset against linear panning and rotation; reserved top bits dropped
    wr(spsr_pkg::OFS_TILEOFF, 32'hf123_f456);
    rd_chk(spsr_pkg::OFS_TILEOFF, 32'h0123_0456);
    upd(3'b100);
    @(posedge clk);
    #1 surface_tiled = 1'b1;
    rotate_180 = 1'b1;
    #1 chk({4'h0, pan_y, 4'h0, pan_x}, 32'h0123_0456, "tiled pan");
    chk(32'(pan_tiled), 32'h0000_0001, "pan tiled");
    chk(pan_linear, 32'h0000_0000, "linear off");
    chk(32'(pan_corner_lr), 32'h0000_0001, "corner");
    @(posedge clk);
    #1 surface_tiled = 1'b0;
    #1 chk({8'h00, pan_y, pan_x}, 32'h0000_0000, "tile ignored");
    chk(32'(pan_tiled), 32'h0000_0000, "pan linear");
    chk(pan_linear, 32'h0bad_cafe, "linear pan");
    chk(32'(pan_corner_lr), 32'h0000_0000, "corner linear");
    // command streamer flip
    @(posedge clk);
    #1 cs_flip = 1'b1;
    cs_flip_addr = 32'habcd_e123;
    @(posedge clk);
    #1 cs_flip = 1'b0;
    chk(32'(armed), 32'h0000_0001, "flip arms");
    rd_chk(spsr_pkg::OFS_SURF, 32'habcd_e000);
    upd(3'b100);
    chk(surface_base, 32'habcd_e000, "flip active");
    // refused writes and unmapped read
    wr(spsr_pkg::OFS_LIVE, 32'hffff_ffff);
    rd_chk(spsr_pkg::OFS_LIVE, 32'habcd_e000);
    rd_chk(20'h7_3200, 32'h0000_0000);
    // last gamma word written and looked up, index past the table
    wr(spsr_pkg::OFS_GAMMA + 20'h0_0048, 32'h0000_03ff);
    rd_chk(spsr_pkg::OFS_GAMMA + 20'h0_0048, 32'h0000_03ff);
    @(posedge clk);
    #1 gamma_idx = 5'h12;
    @(posedge clk);
    #1 chk(gamma_word, 32'h0000_03ff, "gamma lookup");
    gamma_idx = 5'h13;
    @(posedge clk);
    #1 chk(gamma_word, 32'h0000_0000, "gamma past end");
    give_verdict();
  end
endmodule

//--- spsr_dbuf.sv
// spsr_dbuf: one two-stage double-buffered register with pending and active copies
`timescale 1ns/100ps
module spsr_dbuf #(
  parameter logic [31:0] MASK = 32'hffff_ffff
) (
  input  wire logic        clk,     // display clock
  input  wire logic        rst,     // async reset, active high
  input  wire logic        wr_en,   // software write strobe
  input  wire logic [31:0] wr_data, // software write data
  input  wire logic        load,    // transfer pending into active
  output logic      [31:0] pend,    // first stage, read back
  output logic      [31:0] act      // second stage, steers hardware
);
  // first stage holds what software wrote; masked bits stay zero
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pend <= 32'h0000_0000;
    else if (wr_en)
      pend <= wr_data & MASK;

  // second stage takes the pending value only at the update point
  always_ff @(posedge clk or posedge rst)
    if (rst)
      act <= 32'h0000_0000;
    else if (load)
      act <= pend;
endmodule

//--- spsr_pkg.sv
// spsr_pkg: offsets, field positions, reset values and gamma defaults of the sprite register bank
package spsr_pkg;
  localparam logic [19:0] OFS_SURF      = 20'h7_319c;
  localparam logic [19:0] OFS_KEYMAX    = 20'h7_31a0;
  localparam logic [19:0] OFS_TILEOFF   = 20'h7_31a4;
  localparam logic [19:0] OFS_LIVE      = 20'h7_31ac;
  localparam logic [19:0] OFS_SCALE     = 20'h7_3204;
  localparam logic [19:0] OFS_GAMMA     = 20'h7_3300;
  localparam int          GAMMA_WORDS   = 19;
  localparam int          GAMMA_POINTS  = 16;
  // writable bit masks; reserved bits are dropped on write and read as zero
  localparam logic [31:0] MASK_SURF     = 32'hffff_f000;
  localparam logic [31:0] MASK_KEYMAX   = 32'h00ff_ffff;
  localparam logic [31:0] MASK_TILEOFF  = 32'h0fff_0fff;
  localparam logic [31:0] MASK_SCALE    = 32'hffff_07ff;
  localparam logic [31:0] RESET_REG     = 32'h0000_0000;
  // field positions
  localparam int          TILE_Y_LSB    = 16;
  localparam int          TILE_X_LSB    = 0;
  localparam int          KEY_V_LSB     = 16;
  localparam int          KEY_Y_LSB     = 8;
  localparam int          KEY_U_LSB     = 0;
  localparam int          SC_EN_BIT     = 31;
  localparam int          SC_FILT_LSB   = 29;
  localparam int          SC_FOFS_BIT   = 28;
  localparam int          SC_FEN_BIT    = 27;
  localparam int          SC_SRCW_LSB   = 16;
  localparam int          SC_SRCH_LSB   = 0;
  localparam logic [11:0] SRCW_MAX_M1   = 12'h07ff;
  localparam logic [11:0] SRC_MIN_M1    = 12'h0002;
  localparam logic [4:0]  MAX_DOWN      = 5'h10;
  localparam logic [4:0]  DECIM_ABOVE   = 5'h02;
  // gamma reset: point i = {i<<26 | i<<16 | i<<6}, tops = 0x400
  localparam logic [31:0] GAMMA_TOP_RST = 32'h0000_0400;
  localparam logic [31:0] GAMMA_STEP    = 32'h0401_0040;
  // phase encoding: 2'b00 zero, 2'b01 half, 2'b10 half the scale factor
  typedef enum logic [1:0] {SPSR_PH_ZERO, SPSR_PH_HALF, SPSR_PH_SCALE} spsr_phase_t;
endpackage

//--- spsr_regs.sv
// spsr_regs: second sprite plane surface, key, pan, scaler and gamma register bank
//
// Summary of operation
// - a surface base write arms the scaler control for its next update point
// - surface, key max and tiled offset go active at vblank or pipe disable
// - tiled offset pans only tiled surfaces; linear uses the linear offset
// - tiled offset: y start in 27:16, x start in 11:0, from surface start
// - under 180 degree rotation the offset names the lower right corner
// - key max gives V, Y, U upper bounds, used only with source keying
// - a read-only register returns the active surface base address
// - the command streamer can flip the surface base as well
// - scaling enable bit 31 resamples source size to destination size
// - any upscale; downscale to 16:1; beyond 2:1 uses decimation
// - field offset bit picks vertical initial phase zero or one half
// - field enable clear gives phase half the scale factor
// - source width holds pixels minus one, from three up to 2048
// - gamma block is sixteen points then red, green, blue top words
`timescale 1ns/100ps
module spsr_regs #(
  parameter int GAMMA_N = spsr_pkg::GAMMA_WORDS
) (
  input  wire logic        clk,            // display clock, 100 MHz
  input  wire logic        rst,            // async reset, active high
  input  wire logic [19:0] reg_addr,       // byte address of the access
  input  wire logic        reg_wr,         // write strobe, one cycle
  input  wire logic        reg_rd,         // read strobe, one cycle
  input  wire logic [31:0] reg_wdata,      // write data
  output logic      [31:0] reg_rdata,      // read data, registered
  output logic             reg_rvalid,     // read data valid pulse
  input  wire logic        cs_flip,        // command streamer flip strobe
  input  wire logic [31:0] cs_flip_addr,   // flip surface address
  input  wire logic        vblank_start,   // start of vertical blank pulse
  input  wire logic        pipe_disabled,  // pipe off level
  input  wire logic        sprite_disabled, // sprite off level
  input  wire logic        surface_tiled,  // surface is tiled
  input  wire logic        rotate_180,     // 180 degree rotation active
  input  wire logic        src_key_en,     // source colour keying enabled
  input  wire logic [31:0] linear_offset,  // active linear pan offset
  input  wire logic [4:0]  down_ratio,     // source/destination ratio, integer
  input  wire logic [4:0]  gamma_idx,      // gamma word lookup index
  output logic      [31:0] surface_base,   // active surface base
  output logic             pan_tiled,      // panning taken from x,y offset
  output logic      [11:0] pan_x,          // active x start in pixels
  output logic      [11:0] pan_y,          // active y start in lines
  output logic      [31:0] pan_linear,     // active linear offset, linear only
  output logic             pan_corner_lr,  // offset marks lower right corner
  output logic      [7:0]  key_max_v,      // V upper bound, zero when unkeyed
  output logic      [7:0]  key_max_y,      // Y upper bound
  output logic      [7:0]  key_max_u,      // U upper bound
  output logic             scale_en,       // scaling active
  output logic      [1:0]  filter_sel,     // active filter selection
  output logic      [1:0]  vphase,         // vertical initial phase code
  output logic      [11:0] src_width,      // scaled source width in pixels
  output logic      [10:0] src_height_m1,  // source height minus one
  output logic             decimate,       // downscale beyond 2:1
  output logic             scale_ratio_ok, // ratio within 16:1 limit
  output logic             armed,          // armed transfer pending
  output logic      [31:0] gamma_word      // gamma word at gamma_idx, registered
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and update points
  logic        wr_surf;
  logic        wr_key;
  logic        wr_tile;
  logic        wr_scale;
  logic        upd_plain;
  logic        upd_armed;
  logic        armed_r;
  logic [31:0] surf_wdata;
  logic [31:0] surf_pend;
  logic [31:0] surf_act;
  logic [31:0] key_pend;
  logic [31:0] key_act;
  logic [31:0] tile_pend;
  logic [31:0] tile_act;
  logic [31:0] scale_pend;
  logic [31:0] scale_act;

  assign wr_surf  = (reg_wr && reg_addr == spsr_pkg::OFS_SURF) || cs_flip;
  assign wr_key   = reg_wr && reg_addr == spsr_pkg::OFS_KEYMAX;
  assign wr_tile  = reg_wr && reg_addr == spsr_pkg::OFS_TILEOFF;
  assign wr_scale = reg_wr && reg_addr == spsr_pkg::OFS_SCALE;
  // a streamer flip wins over a same-cycle software write to the surface
  assign surf_wdata = cs_flip ? cs_flip_addr : reg_wdata;

  // unarmed registers follow vblank or pipe disable alone
  assign upd_plain = vblank_start || pipe_disabled;
  // armed registers also take sprite disable, but only while armed
  assign upd_armed = armed_r && (vblank_start || pipe_disabled || sprite_disabled);

  ////////////////////////////////////////////////////////////////////////////
  // arming flag: a new arm in the update cycle is kept, so no arm is lost
  always_ff @(posedge clk or posedge rst)
    if (rst)
      armed_r <= 1'b0;
    else if (wr_surf)
      armed_r <= 1'b1;
    else if (upd_armed)
      armed_r <= 1'b0;

  assign armed = armed_r;

  ////////////////////////////////////////////////////////////////////////////
  // double-buffered registers; masks drop reserved bits on write
  spsr_dbuf #(.MASK(spsr_pkg::MASK_SURF)) u_surf (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_surf),
    .wr_data (surf_wdata),
    .load    (upd_plain),
    .pend    (surf_pend),
    .act     (surf_act)
  );

  spsr_dbuf #(.MASK(spsr_pkg::MASK_KEYMAX)) u_key (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_key),
    .wr_data (reg_wdata),
    .load    (upd_plain),
    .pend    (key_pend),
    .act     (key_act)
  );

  spsr_dbuf #(.MASK(spsr_pkg::MASK_TILEOFF)) u_tile (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_tile),
    .wr_data (reg_wdata),
    .load    (upd_plain),
    .pend    (tile_pend),
    .act     (tile_act)
  );

  // scaler control waits for the arm, keeping size and scale atomic
  spsr_dbuf #(.MASK(spsr_pkg::MASK_SCALE)) u_scale (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_scale),
    .wr_data (reg_wdata),
    .load    (upd_armed),
    .pend    (scale_pend),
    .act     (scale_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // gamma table: 16 points then red, green, blue tops, reset to an identity ramp
  logic [31:0] gamma_mem [GAMMA_N];
  logic [4:0]  gamma_wsel;
  logic        gamma_hit;
  logic [19:0] gamma_rel;

  assign gamma_rel  = reg_addr - spsr_pkg::OFS_GAMMA;
  assign gamma_hit  = reg_addr >= spsr_pkg::OFS_GAMMA && gamma_rel[1:0] == 2'b00
                      && gamma_rel[19:2] < 18'(GAMMA_N);
  assign gamma_wsel = gamma_rel[6:2];

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < GAMMA_N; i++)
        gamma_mem[i] <= (i < spsr_pkg::GAMMA_POINTS)
                        ? 32'(spsr_pkg::GAMMA_STEP * 32'(i))
                        : spsr_pkg::GAMMA_TOP_RST;
    end
    else if (reg_wr && gamma_hit)
      gamma_mem[gamma_wsel] <= reg_wdata;

  // lookup port for the colour pipeline; out-of-range index reads zero
  always_ff @(posedge clk or posedge rst)
    if (rst)
      gamma_word <= 32'h0000_0000;
    else if (32'(gamma_idx) < 32'(GAMMA_N))
      gamma_word <= gamma_mem[gamma_idx];
    else
      gamma_word <= 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // register read: pending values read back, live register shows the active one
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (reg_addr == spsr_pkg::OFS_SURF)
          reg_rdata <= surf_pend;
        else if (reg_addr == spsr_pkg::OFS_KEYMAX)
          reg_rdata <= key_pend;
        else if (reg_addr == spsr_pkg::OFS_TILEOFF)
          reg_rdata <= tile_pend;
        else if (reg_addr == spsr_pkg::OFS_LIVE)
          reg_rdata <= surf_act;
        else if (reg_addr == spsr_pkg::OFS_SCALE)
          reg_rdata <= scale_pend;
        else if (gamma_hit)
          reg_rdata <= gamma_mem[gamma_wsel];
        else
          reg_rdata <= 32'h0000_0000; // unmapped and reserved read zero
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // panning selection: tiled takes x,y, linear takes the linear offset
  assign surface_base  = surf_act;
  assign pan_tiled     = surface_tiled;
  assign pan_x         = surface_tiled ? tile_act[spsr_pkg::TILE_X_LSB +: 12] : 12'h000;
  assign pan_y         = surface_tiled ? tile_act[spsr_pkg::TILE_Y_LSB +: 12] : 12'h000;
  assign pan_linear    = surface_tiled ? 32'h0000_0000 : linear_offset;
  // under rotation the same fields locate the unrotated lower right corner
  assign pan_corner_lr = surface_tiled && rotate_180;

  // key bounds are neutral (zero) unless source keying is on
  assign key_max_v = src_key_en ? key_act[spsr_pkg::KEY_V_LSB +: 8] : 8'h00;
  assign key_max_y = src_key_en ? key_act[spsr_pkg::KEY_Y_LSB +: 8] : 8'h00;
  assign key_max_u = src_key_en ? key_act[spsr_pkg::KEY_U_LSB +: 8] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // scaler decode from the active stage
  spsr_pkg::spsr_phase_t vphase_sel;

  assign scale_en      = scale_act[spsr_pkg::SC_EN_BIT];
  assign filter_sel    = scale_act[spsr_pkg::SC_FILT_LSB +: 2];
  // width field holds pixels minus one; clamp to the supported 3..2048 span
  assign src_width     = (12'({1'b0, scale_act[spsr_pkg::SC_SRCW_LSB +: 11]})
                          < spsr_pkg::SRC_MIN_M1 ? spsr_pkg::SRC_MIN_M1
                          : 12'({1'b0, scale_act[spsr_pkg::SC_SRCW_LSB +: 11]}))
                         + 12'h001;
  assign src_height_m1 = scale_act[spsr_pkg::SC_SRCH_LSB +: 11];
  // ratio checks only matter while scaling; upscale (ratio 0) always passes
  assign scale_ratio_ok = !scale_en || down_ratio <= spsr_pkg::MAX_DOWN;
  assign decimate       = scale_en && down_ratio > spsr_pkg::DECIM_ABOVE;

  always_comb
  begin
    if (!scale_act[spsr_pkg::SC_FEN_BIT])
      vphase_sel = spsr_pkg::SPSR_PH_SCALE;
    else if (scale_act[spsr_pkg::SC_FOFS_BIT])
      vphase_sel = spsr_pkg::SPSR_PH_HALF;
    else
      vphase_sel = spsr_pkg::SPSR_PH_ZERO;
  end
  assign vphase = vphase_sel;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence surf_written_s;
    wr_surf;
  endsequence

  sequence armed_update_s;
    armed_r && (vblank_start || pipe_disabled || sprite_disabled) && !wr_surf;
  endsequence

  arm_on_write_a: assert property (@(posedge clk) disable iff (rst)
    surf_written_s |=> armed_r)
    else $error("surface write did not arm");

  arm_clear_a: assert property (@(posedge clk) disable iff (rst)
    armed_update_s |=> !armed_r)
    else $error("arm flag did not clear at update");

  scale_hold_a: assert property (@(posedge clk) disable iff (rst)
    !upd_armed |=> $stable(scale_act))
    else $error("scaler control changed without armed update");

  surf_xfer_a: assert property (@(posedge clk) disable iff (rst)
    upd_plain |=> surf_act == $past(surf_pend))
    else $error("surface not transferred at update point");

  live_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == spsr_pkg::OFS_LIVE |=> reg_rvalid && reg_rdata == $past(surf_act))
    else $error("live read did not return active address");

  surf_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    surf_pend[11:0] == 12'h000 && tile_pend[31:28] == 4'h0 && key_pend[31:24] == 8'h00)
    else $error("reserved bits not zero");

  pan_linear_a: assert property (@(posedge clk) disable iff (rst)
    !surface_tiled |-> pan_x == 12'h000 && pan_y == 12'h000 && pan_linear == linear_offset)
    else $error("tiled offset used for linear surface");

  key_gate_a: assert property (@(posedge clk) disable iff (rst)
    !src_key_en |-> {key_max_v, key_max_y, key_max_u} == 24'h00_0000)
    else $error("key bound active without source keying");

  phase_sel_a: assert property (@(posedge clk) disable iff (rst)
    scale_act[spsr_pkg::SC_FEN_BIT] |-> vphase == {1'b0, scale_act[spsr_pkg::SC_FOFS_BIT]})
    else $error("vertical phase does not follow field offset");

  flip_arm_a: assert property (@(posedge clk) disable iff (rst)
    cs_flip |=> surf_pend == ($past(cs_flip_addr) & spsr_pkg::MASK_SURF) && armed_r)
    else $error("streamer flip not taken");

  // plain update point: no arming needed for surface, key bounds and pan offset
  sequence plain_update_s;
    vblank_start || pipe_disabled;
  endsequence

  key_xfer_a: assert property (@(posedge clk) disable iff (rst)
    plain_update_s |=> key_act == $past(key_pend))
    else $error("key bounds not transferred at update point");

  tile_xfer_a: assert property (@(posedge clk) disable iff (rst)
    plain_update_s |=> tile_act == $past(tile_pend))
    else $error("tiled offset not transferred at update point");

  // a moving active stage between update points would tear the displayed frame
  plain_hold_a: assert property (@(posedge clk) disable iff (rst)
    !upd_plain |=> $stable(surf_act) && $stable(key_act) && $stable(tile_act))
    else $error("active stage changed between update points");

  scale_xfer_a: assert property (@(posedge clk) disable iff (rst)
    upd_armed |=> scale_act == $past(scale_pend))
    else $error("scaler control not transferred on armed update");

  width_span_a: assert property (@(posedge clk) disable iff (rst)
    src_width >= 12'h003 && src_width <= 12'h800)
    else $error("source width outside supported span");

  decim_gate_a: assert property (@(posedge clk) disable iff (rst)
    decimate |-> scale_en && down_ratio > spsr_pkg::DECIM_ABOVE)
    else $error("decimation without a large downscale");

  // the lookup must not alias past the three top words
  gamma_range_a: assert property (@(posedge clk) disable iff (rst)
    32'(gamma_idx) >= 32'(GAMMA_N) |=> gamma_word == 32'h0000_0000)
    else $error("gamma lookup past the table not zero");

  corner_gate_a: assert property (@(posedge clk) disable iff (rst)
    pan_corner_lr |-> pan_tiled && rotate_180)
    else $error("corner mode without tiled rotation");
endmodule
